// ### rtl/ssov_pkg.sv
// Package for the socket status override block: offsets, fields, reset values and types.
package ssov_pkg;

  localparam logic [7:0] SSOV_EVENT_OFF = 8'h00;
  localparam logic [7:0] SSOV_EVMASK_OFF = 8'h04;
  localparam logic [7:0] SSOV_PRESENT_OFF = 8'h08;
  localparam logic [7:0] SSOV_OVERRIDE_OFF = 8'h0c;
  localparam logic [7:0] SSOV_CTRL_OFF = 8'h10;
  localparam logic [7:0] SSOV_IRQ_STAT_OFF = 8'h14;
  localparam logic [7:0] SSOV_IRQ_MASK_OFF = 8'h18;

  // Override register field positions.
  localparam int SSOV_B_STS = 0;
  localparam int SSOV_B_DETA = 1;
  localparam int SSOV_B_DETB = 2;
  localparam int SSOV_B_PWR = 3;
  localparam int SSOV_B_NARROW = 4;
  localparam int SSOV_B_WIDE = 5;
  localparam int SSOV_B_UNREC = 7;
  localparam int SSOV_B_LOSS = 8;
  localparam int SSOV_B_BADREQ = 9;
  localparam int SSOV_B_V5 = 10;
  localparam int SSOV_B_V3 = 11;
  localparam int SSOV_B_VX = 12;
  localparam int SSOV_B_VY = 13;
  localparam int SSOV_B_REINT = 14;

  // Present-state bits 31..28 report socket capability.
  localparam logic [3:0] SSOV_SOCKET_CAPS = 4'h3;
  localparam logic [13:0] SSOV_PRESENT_RST = 14'h0000;
  localparam logic [3:0] SSOV_EVENT_RST = 4'h0;

  // Interrupt status bits.
  localparam int SSOV_I_FORCE = 0;
  localparam int SSOV_I_REINT = 1;
  localparam int SSOV_I_AUTOOFF = 2;
  localparam logic [2:0] SSOV_IRQ_RST = 3'h0;

  // Interrogation result presented by the card interface.
  typedef struct packed {
    logic yy_volt;
    logic xx_volt;
    logic three_volt;
    logic five_volt;
    logic unrecognized;
    logic wide;
    logic narrow;
  } ssov_card_id_t;

  // Live socket pins mirrored into the present-state register.
  typedef struct packed {
    logic status_change;
    logic detect_b;
    logic detect_a;
    logic power_state;
    logic ready;
  } ssov_pins_t;

  typedef enum logic [2:0] {
    SSOV_IDLE = 3'b001,
    SSOV_ASK = 3'b010,
    SSOV_WAIT = 3'b100
  } ssov_state_t;

endpackage : ssov_pkg

// ### rtl/ssov_top.sv
// Socket status override register bank with APB slave, event and present-state flags.
`timescale 1ns/1ps
`default_nettype none

module ssov_top (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire ssov_pkg::ssov_pins_t i_pins,
  input wire logic [3:0] i_pin_events,
  input wire ssov_pkg::ssov_card_id_t i_card_id,
  input wire logic i_interrogate_done,
  output logic o_interrogate_req,
  output logic o_auto_power_en,
  output logic o_irq
);

  logic setup_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [3:0] event_ff;
  logic [3:0] nxt_event;
  logic [3:0] evmask_ff;
  logic [3:0] volt_support_ff;
  logic bad_supply_request_ff;
  logic data_loss_ff;
  logic unrecognized_card_ff;
  logic wide_card_ff;
  logic narrow_card_ff;
  logic auto_power_ff;
  logic [2:0] irq_stat_ff;
  logic [2:0] nxt_irq_stat;
  logic [2:0] irq_mask_ff;
  logic [2:0] nxt_irq_mask;
  logic irq_ff;
  ssov_pkg::ssov_state_t state_ff;
  ssov_pkg::ssov_state_t nxt_state;

  logic setup_phase;
  logic wr_acc;
  logic rd_acc;
  logic wr_event;
  logic wr_evmask;
  logic wr_ovr;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic reint_req;
  logic volt_force;
  logic interrogate_end;
  logic [2:0] irq_events;
  logic [31:0] event_word;
  logic [31:0] evmask_word;
  logic [31:0] present_word;
  logic [31:0] override_word;
  logic [31:0] ctrl_word;
  logic [31:0] irq_stat_word;
  logic [31:0] irq_mask_word;
  logic [31:0] rd_word;
  logic rd_hit;

  // A setup cycle has psel high and penable still low. The slave answers in the
  // first cycle of the access phase, so no wait state is ever inserted and a write
  // takes effect at the rising edge that ends that cycle.
  assign setup_phase = i_psel && !i_penable;
  assign wr_acc = i_psel && i_penable && setup_ff && i_pwrite;
  assign rd_acc = setup_phase && !i_pwrite;

  // Write strobes, one for each register that software may write.
  assign wr_event = wr_acc && (i_paddr == ssov_pkg::SSOV_EVENT_OFF);
  assign wr_evmask = wr_acc && (i_paddr == ssov_pkg::SSOV_EVMASK_OFF);
  assign wr_ovr = wr_acc && (i_paddr == ssov_pkg::SSOV_OVERRIDE_OFF);
  assign wr_irq_stat = wr_acc && (i_paddr == ssov_pkg::SSOV_IRQ_STAT_OFF);
  assign wr_irq_mask = wr_acc && (i_paddr == ssov_pkg::SSOV_IRQ_MASK_OFF);

  // Trigger bit starts a new interrogation.
  assign reint_req = wr_ovr && i_pwdata[ssov_pkg::SSOV_B_REINT];
  assign volt_force = wr_ovr && (|i_pwdata[ssov_pkg::SSOV_B_VY:ssov_pkg::SSOV_B_V5]);
  assign interrogate_end = (state_ff == ssov_pkg::SSOV_WAIT) && i_interrogate_done;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      setup_ff <= 1'b0;
    end else begin
      setup_ff <= setup_phase;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= setup_phase;
    end
  end

  // Event bits: a pin event sets, a written one clears, a force copies the written bit.
  // A pin event wins over both, so a real socket event is never lost to software.
  for (genvar gi = 0; gi < 4; gi++) begin : g_event
    assign nxt_event[gi] = i_pin_events[gi] ? 1'b1 :
                           wr_ovr ? i_pwdata[gi] :
                           (wr_event && i_pwdata[gi]) ? 1'b0 :
                           event_ff[gi];
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      event_ff <= ssov_pkg::SSOV_EVENT_RST;
    end else begin
      event_ff <= nxt_event;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      evmask_ff <= 4'h0;
    end else if (wr_evmask) begin
      evmask_ff <= i_pwdata[3:0];
    end
  end

  // Present-state flags follow a force write; all but bits 9 and 8 also take the result of a new interrogation.
  // Bits 6 and 3..0 are live pins and are never stored here.
  // Voltage-support flags.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      volt_support_ff <= ssov_pkg::SSOV_PRESENT_RST[13:10];
    end else if (wr_ovr) begin
      volt_support_ff <= i_pwdata[ssov_pkg::SSOV_B_VY:ssov_pkg::SSOV_B_V5];
    end else if (interrogate_end) begin
      volt_support_ff <= {i_card_id.yy_volt, i_card_id.xx_volt,
                          i_card_id.three_volt, i_card_id.five_volt};
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bad_supply_request_ff <= ssov_pkg::SSOV_PRESENT_RST[9];
    end else if (wr_ovr) begin
      bad_supply_request_ff <= i_pwdata[ssov_pkg::SSOV_B_BADREQ];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      data_loss_ff <= ssov_pkg::SSOV_PRESENT_RST[8];
    end else if (wr_ovr) begin
      data_loss_ff <= i_pwdata[ssov_pkg::SSOV_B_LOSS];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      unrecognized_card_ff <= ssov_pkg::SSOV_PRESENT_RST[7];
    end else if (wr_ovr) begin
      unrecognized_card_ff <= i_pwdata[ssov_pkg::SSOV_B_UNREC];
    end else if (interrogate_end) begin
      unrecognized_card_ff <= i_card_id.unrecognized;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wide_card_ff <= ssov_pkg::SSOV_PRESENT_RST[5];
    end else if (wr_ovr) begin
      wide_card_ff <= i_pwdata[ssov_pkg::SSOV_B_WIDE];
    end else if (interrogate_end) begin
      wide_card_ff <= i_card_id.wide;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      narrow_card_ff <= ssov_pkg::SSOV_PRESENT_RST[4];
    end else if (wr_ovr) begin
      narrow_card_ff <= i_pwdata[ssov_pkg::SSOV_B_NARROW];
    end else if (interrogate_end) begin
      narrow_card_ff <= i_card_id.narrow;
    end
  end

  // Interrogation sequencer.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ssov_pkg::SSOV_IDLE: begin
        if (reint_req) begin
          nxt_state = ssov_pkg::SSOV_ASK;
        end
      end
      ssov_pkg::SSOV_ASK: begin
        nxt_state = ssov_pkg::SSOV_WAIT;
      end
      ssov_pkg::SSOV_WAIT: begin
        if (i_interrogate_done) begin
          nxt_state = ssov_pkg::SSOV_IDLE;
        end
      end
      default: begin
        nxt_state = ssov_pkg::SSOV_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= ssov_pkg::SSOV_IDLE;
      o_interrogate_req <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      o_interrogate_req <= (nxt_state == ssov_pkg::SSOV_ASK);
    end
  end

  // Automatic power control: a voltage force switches it off, the trigger back on.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      auto_power_ff <= 1'b1;
    end else if (reint_req) begin
      auto_power_ff <= 1'b1;
    end else if (volt_force) begin
      auto_power_ff <= 1'b0;
    end
  end

  assign o_auto_power_en = auto_power_ff;

  // Interrupt causes: any override write, the end of an interrogation, and power
  // control being switched off.
  assign irq_events[ssov_pkg::SSOV_I_FORCE] = wr_ovr;
  assign irq_events[ssov_pkg::SSOV_I_REINT] = interrogate_end;
  // A voltage force switches power control off unless the trigger overrules it.
  assign irq_events[ssov_pkg::SSOV_I_AUTOOFF] = volt_force && !reint_req;

  // Sticky status: a new event wins over a clear in the same cycle.
  for (genvar gj = 0; gj < 3; gj++) begin : g_irq_stat
    assign nxt_irq_stat[gj] = irq_events[gj] ? 1'b1 :
                              (wr_irq_stat && i_pwdata[gj]) ? 1'b0 :
                              irq_stat_ff[gj];
  end

  always_comb begin
    if (wr_irq_mask) begin
      nxt_irq_mask = i_pwdata[2:0];
    end else begin
      nxt_irq_mask = irq_mask_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_stat_ff <= ssov_pkg::SSOV_IRQ_RST;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_mask_ff <= 3'h0;
    end else begin
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // The line is built from the next status and mask, so it moves in the same cycle
  // as they do and never lags a clear or a mask write.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_irq_stat & nxt_irq_mask);
    end
  end

  // Read words, one for each register.
  assign event_word = {28'h000_0000, event_ff};
  assign evmask_word = {28'h000_0000, evmask_ff};
  assign present_word = {
    ssov_pkg::SSOV_SOCKET_CAPS,
    14'h0000,
    volt_support_ff,
    bad_supply_request_ff,
    data_loss_ff,
    unrecognized_card_ff,
    i_pins.ready,
    wide_card_ff,
    narrow_card_ff,
    i_pins.power_state,
    i_pins.detect_b,
    i_pins.detect_a,
    i_pins.status_change
  };
  // The override word reads zero; its force bits are write-only.
  assign override_word = 32'h0000_0000;
  assign ctrl_word = {
    29'h0000_0000,
    state_ff != ssov_pkg::SSOV_IDLE,
    1'b0,
    auto_power_ff
  };
  assign irq_stat_word = {29'h0000_0000, irq_stat_ff};
  assign irq_mask_word = {29'h0000_0000, irq_mask_ff};

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (i_paddr == ssov_pkg::SSOV_EVENT_OFF) begin
      rd_word = event_word;
    end else if (i_paddr == ssov_pkg::SSOV_EVMASK_OFF) begin
      rd_word = evmask_word;
    end else if (i_paddr == ssov_pkg::SSOV_PRESENT_OFF) begin
      rd_word = present_word;
    end else if (i_paddr == ssov_pkg::SSOV_OVERRIDE_OFF) begin
      rd_word = override_word;
    end else if (i_paddr == ssov_pkg::SSOV_CTRL_OFF) begin
      rd_word = ctrl_word;
    end else if (i_paddr == ssov_pkg::SSOV_IRQ_STAT_OFF) begin
      rd_word = irq_stat_word;
    end else if (i_paddr == ssov_pkg::SSOV_IRQ_MASK_OFF) begin
      rd_word = irq_mask_word;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read data is captured in the setup cycle and stands through the access cycle.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata_ff <= rd_acc ? rd_word : 32'h0000_0000;
    end
  end

  // An unmapped address is refused in either direction.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pslverr_ff <= 1'b0;
    end else if (setup_phase) begin
      pslverr_ff <= !rd_hit;
    end
  end

  assign o_prdata = prdata_ff;
  assign o_pslverr = pslverr_ff;
  assign o_irq = irq_ff;

endmodule : ssov_top

`default_nettype wire

// ### testbench/ssov_top_properties.sv
// Concurrent checks on the socket status override ports.
`timescale 1ns/1ps
`default_nettype none
module ssov_checker (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_interrogate_req,
  input wire logic o_auto_power_en
);
  logic acc;
  logic wr_ov;
  assign acc = i_psel && i_penable && o_pready;
  assign wr_ov = acc && i_pwrite && (i_paddr == 8'h0c);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  chk_setup_answer: assert property (i_psel && !i_penable |=> o_pready)
    else $error("Ready missing after setup.");
  chk_ready_single: assert property (o_pready |=> !o_pready)
    else $error("Ready held too long.");
  chk_override_zero: assert property (acc && !i_pwrite && i_paddr == 8'h0c |->
    o_prdata == 32'h0 && !o_pslverr) else $error("Override read not zero.");
  chk_present_fixed: assert property (acc && !i_pwrite && i_paddr == 8'h08 |->
    o_prdata[31:14] == 18'h0c000) else $error("Present fixed bits wrong.");
  chk_volt_disable: assert property (wr_ov && i_pwdata[13:10] != 4'h0 && !i_pwdata[14]
    |=> !o_auto_power_en) else $error("Power control not disabled.");
  chk_trigger_enable: assert property (wr_ov && i_pwdata[14] |=> o_auto_power_en)
    else $error("Power control not re-enabled.");
  chk_req_pulse: assert property (o_interrogate_req |=> !o_interrogate_req)
    else $error("Interrogation request too long.");
  chk_power_cause: assert property ($changed(o_auto_power_en) |-> $past(wr_ov))
    else $error("Power control changed without a write.");
  chk_unmapped_err: assert property (acc && i_paddr > 8'h18 |-> o_pslverr)
    else $error("Unmapped access not refused.");
endmodule : ssov_checker
bind ssov_top ssov_checker ssov_checker_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_interrogate_req(o_interrogate_req), .o_auto_power_en(o_auto_power_en));
`default_nettype wire

// ### testbench/ssov_top_tb.sv
// Self-checking bench for the socket status override register bank.
`timescale 1ns/1ps
`default_nettype none
module ssov_top_tb;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_interrogate_req, o_auto_power_en, o_irq;
  // Status-change and power-state pins high, so present bits 0 and 3 read one.
  ssov_pkg::ssov_pins_t i_pins = 5'h12;
  ssov_pkg::ssov_card_id_t i_card_id = 7'h55;
  logic i_interrogate_done = 1'b0;
  logic [31:0] rd;
  logic er;
  int n;
  int err_total = 0;
  int comparisons = 0;
  always #20 i_clk = ~i_clk;
  ssov_top ssov_top_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_pins(i_pins),
    .i_pin_events(4'h0), .i_card_id(i_card_id), .i_interrogate_done(i_interrogate_done),
    .o_interrogate_req(o_interrogate_req), .o_auto_power_en(o_auto_power_en), .o_irq(o_irq));
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One APB transfer. Ready, read data and error are sampled at the falling edge just
  // before the rising edge that ends the access, where they stand unchanged.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic rdy;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(negedge i_clk);
      rdy = o_pready;
      rd = o_prdata;
      er = o_pslverr;
      @(posedge i_clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (n >= 20) begin
      err_total++;
      wrap_up();
    end
    @(negedge i_clk);
  endtask : apb
  initial begin
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    chk("power after reset", 32'h1, {31'h0, o_auto_power_en});
    apb(1'b1, 8'h18, 32'h7);
    chk("irq idle", 32'h0, {31'h0, o_irq});
    apb(1'b1, 8'h0c, 32'h0000_3fbf);
    chk("power after force", 32'h0, {31'h0, o_auto_power_en});
    chk("irq raised", 32'h1, {31'h0, o_irq});
    apb(1'b0, 8'h08, 32'h0);
    chk("present forced", 32'h3000_3fb9, rd);
    apb(1'b0, 8'h00, 32'h0);
    chk("events forced", 32'h0000_000f, rd);
    apb(1'b0, 8'h0c, 32'h0);
    chk("override read", 32'h0, rd);
    apb(1'b0, 8'h14, 32'h0);
    chk("irq status set", 32'h5, rd);
    apb(1'b1, 8'h18, 32'h0);
    chk("irq masked", 32'h0, {31'h0, o_irq});
    apb(1'b1, 8'h14, 32'h7);
    apb(1'b0, 8'h14, 32'h0);
    chk("irq status cleared", 32'h0, rd);
    chk("irq cleared", 32'h0, {31'h0, o_irq});
    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk("present cleared", 32'h3000_0009, rd);
    apb(1'b0, 8'h00, 32'h0);
    chk("events cleared", 32'h0, rd);
    chk("power stays off", 32'h0, {31'h0, o_auto_power_en});
    apb(1'b1, 8'h0c, 32'h0000_4000);
    n = 0;
    while (o_interrogate_req !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    chk("interrogation request", 32'h1, {31'h0, o_interrogate_req});
    @(posedge i_clk);
    i_interrogate_done <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_interrogate_done <= 1'b0;
    chk("power re-enabled", 32'h1, {31'h0, o_auto_power_en});
    apb(1'b0, 8'h08, 32'h0);
    chk("present refreshed", 32'h3000_2899, rd);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    wrap_up();
  end
endmodule : ssov_top_tb
`default_nettype wire
